// ---- common/upstream_cfg.svh ----
// timing counts, limits and reset values for the upstream burst timing pair
// What this block does
// - launch each burst its ranging advance before its granted time
// - accept and use any descriptor burst profile
// - ranging offset 16 bits, 1/64 tick units
// - negative adjustment lowers offset, later launch
// - head-end sends corrections in 1/64 tick units
// - correction applied with one-cycle timing resolution
// - offset frequency within 32 kHz, 1 Hz steps
// - variable grant length 1 to 255 mini-slots
// - hold 64 four-byte equalizer coefficients
// - profile switches need no gap unless parameters change
// - rate, offset, ranging, modulation need 96 symbols
// - channel change needs 96 symbols plus 100 ms
// - power change needs 96 symbols plus 5/10 us
// - changes only while no burst energy pending
// - head-end widens guard by negative adjustment
// - power level 8 to 55/58 dBmV, 1 dB
// - round power steps, halfway picks smaller step
`ifndef UPSTREAM_CFG_SVH
`define UPSTREAM_CFG_SVH
`define CLK_HZ 50000000
`define CLK_MHZ (`CLK_HZ / 1000000)
`define GAP_SYMS 96
`define PWR_SMALL_NS 5000
`define PWR_LARGE_NS 10000
`define CHAN_MS 100
`define PWR_SMALL_CYC ((`PWR_SMALL_NS * `CLK_MHZ + 999) / 1000)
`define PWR_LARGE_CYC ((`PWR_LARGE_NS * `CLK_MHZ + 999) / 1000)
`define CHAN_CYC (`CHAN_MS * (`CLK_HZ / 1000))
`define RNG_TICK_NS 6250
`define RNG_DIV 64
`define RNG_NUM (`RNG_TICK_NS * `CLK_MHZ)
`define RNG_DEN (1000 * `RNG_DIV)
`define RNG_MAX 65535
`define PWR_MIN 8
`define PWR_MAX_QAM16 55
`define PWR_MAX_QPSK 58
`define PWR_RST 8
`define FOFS_MAX 32000
`define NPROF 16
`define NEQ 64
`define SYM_RATE_0 2560000
`define SYM_RATE_1 1280000
`define SYM_RATE_2 640000
`define SYM_RATE_3 320000
`define SYM_RATE_4 160000
`define TS_PERIOD 1024
`endif

// ---- common/upstream_pkg.sv ----
// types shared by both ends of the upstream link
`include "upstream_cfg.svh"
package upstream_pkg;
  typedef enum logic {MOD_QPSK = 1'b0, MOD_QAM16 = 1'b1} mod_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_BURST = 2'b01} tx_state_t;
  typedef logic [2:0] rate_t;

  // least whole cycles per symbol; unknown codes fall back to the slowest
  function automatic logic [9:0] sym_cycles(input rate_t r);
    case (r)
      3'h0: sym_cycles = 10'((`CLK_HZ + `SYM_RATE_0 - 1) / `SYM_RATE_0);
      3'h1: sym_cycles = 10'((`CLK_HZ + `SYM_RATE_1 - 1) / `SYM_RATE_1);
      3'h2: sym_cycles = 10'((`CLK_HZ + `SYM_RATE_2 - 1) / `SYM_RATE_2);
      3'h3: sym_cycles = 10'((`CLK_HZ + `SYM_RATE_3 - 1) / `SYM_RATE_3);
      default: sym_cycles = 10'((`CLK_HZ + `SYM_RATE_4 - 1) / `SYM_RATE_4);
    endcase
  endfunction
endpackage

// ---- common/upstream_link_if.sv ----
// link between the head-end scheduler and the cable modem burst timer
`timescale 1ns/1ps
`default_nettype none
interface upstream_link_if;
  logic ts_valid;
  logic [31:0] ts_time;
  logic ucd_valid;
  upstream_pkg::rate_t ucd_rate;
  logic [15:0] ucd_slot_cyc;
  logic [3:0] ucd_prof_idx;
  upstream_pkg::mod_t ucd_prof_mod;
  logic grant_valid;
  logic [31:0] grant_time;
  logic [7:0] grant_len;
  logic [3:0] grant_prof;
  logic rng_valid;
  logic signed [15:0] rng_adj;
  logic pwr_valid;
  logic pwr_abs;
  logic signed [9:0] pwr_val;
  logic fofs_valid;
  logic signed [16:0] fofs_hz;
  logic chan_valid;
  logic [31:0] chan_hz;
  logic eq_valid;
  logic [5:0] eq_idx;
  logic [31:0] eq_coef;
  logic burst_on;

  modport head_end (
    output ts_valid, ts_time, ucd_valid, ucd_rate, ucd_slot_cyc,
    output ucd_prof_idx, ucd_prof_mod, grant_valid, grant_time,
    output grant_len, grant_prof, rng_valid, rng_adj, pwr_valid,
    output pwr_abs, pwr_val, fofs_valid, fofs_hz, chan_valid, chan_hz,
    output eq_valid, eq_idx, eq_coef,
    input burst_on
  );
  modport modem (
    input ts_valid, ts_time, ucd_valid, ucd_rate, ucd_slot_cyc,
    input ucd_prof_idx, ucd_prof_mod, grant_valid, grant_time,
    input grant_len, grant_prof, rng_valid, rng_adj, pwr_valid,
    input pwr_abs, pwr_val, fofs_valid, fofs_hz, chan_valid, chan_hz,
    input eq_valid, eq_idx, eq_coef,
    output burst_on
  );
endinterface
`default_nettype wire

// ---- logic/cable_modem_burst.sv ----
// cable modem end: burst launch timing, ranging advance and change gating
`timescale 1ns/1ps
`default_nettype none
`include "upstream_cfg.svh"
module cable_modem_burst #(
  parameter int CHAN_CYC = `CHAN_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  upstream_link_if.modem link,
  input wire logic [5:0] eq_rd_idx,
  output logic tx_on,
  output logic [3:0] tx_prof,
  output upstream_pkg::mod_t tx_mod,
  output upstream_pkg::rate_t tx_rate,
  output logic [5:0] tx_power,
  output logic signed [16:0] tx_fofs,
  output logic [31:0] tx_chan,
  output logic [15:0] tx_rng,
  output logic tx_skip,
  output logic change_held,
  output logic [31:0] eq_rd_data
);
  // descriptor profiles and equalizer taps, written straight from the link
  upstream_pkg::mod_t prof_mod [`NPROF];
  logic [31:0] eq_mem [`NEQ];
  logic [15:0] slot_cyc;

  always_ff @(posedge clk) begin
    if (link.ucd_valid) begin
      prof_mod[link.ucd_prof_idx] <= link.ucd_prof_mod;
    end
    if (link.eq_valid) begin
      eq_mem[link.eq_idx] <= link.eq_coef;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_cyc <= 16'h0001;
      eq_rd_data <= 32'h0;
    end else begin
      if (link.ucd_valid && link.ucd_slot_cyc != 16'h0) begin
        slot_cyc <= link.ucd_slot_cyc;
      end
      eq_rd_data <= eq_mem[eq_rd_idx];
    end
  end

  upstream_pkg::tx_state_t state, next_state;
  logic [31:0] now, next_now, g_time, next_g_time;
  logic [7:0] g_len, next_g_len;
  logic [3:0] g_prof, next_g_prof, next_tx_prof;
  logic g_full, next_g_full, next_tx_on, next_tx_skip;
  logic [23:0] burst_cnt, next_burst_cnt, gap_cnt, next_gap_cnt;
  upstream_pkg::mod_t next_tx_mod;
  upstream_pkg::rate_t next_tx_rate, p_rate, next_p_rate;
  logic [5:0] next_tx_power, p_pwr, next_p_pwr;
  logic signed [16:0] next_tx_fofs, p_fofs, next_p_fofs;
  logic [31:0] next_tx_chan, p_chan, next_p_chan;
  logic [15:0] next_tx_rng, p_rng, next_p_rng;
  logic f_pwr, f_big, f_fofs, f_rng, f_chan, f_rate;
  logic next_f_pwr, next_f_big, next_f_fofs, next_f_rng, next_f_chan;
  logic next_f_rate;

  // helpers for the launch decision and the command arithmetic
  logic [19:0] adv;
  logic [23:0] need, gap96;
  logic [31:0] lead;
  logic mod_chg, due, ok, sym_chg;
  logic [5:0] pbase, pmax, plim;
  logic signed [9:0] preq;
  logic [9:0] pmag;
  logic [7:0] pstep;
  logic signed [8:0] psum;
  logic signed [17:0] rsum;
  logic signed [16:0] fcl;
  upstream_pkg::mod_t gmod;

  // advance in cycles from the offset in force; one cycle is finer
  // than any symbol, so no extra rounding is needed
  assign adv = 20'(({24'h0, tx_rng} * 40'(`RNG_NUM)) / 40'(`RNG_DEN));
  assign gap96 = 24'(upstream_pkg::sym_cycles(tx_rate)) * 24'(`GAP_SYMS);
  assign lead = now + 32'(adv);
  assign gmod = prof_mod[g_prof];

  always_comb begin
    next_now = link.ts_valid ? link.ts_time : now + 32'h1;
    next_state = state;
    next_g_full = g_full;
    next_g_time = g_time;
    next_g_len = g_len;
    next_g_prof = g_prof;
    next_burst_cnt = burst_cnt;
    next_gap_cnt = gap_cnt;
    next_tx_on = tx_on;
    next_tx_prof = tx_prof;
    next_tx_mod = tx_mod;
    next_tx_rate = tx_rate;
    next_tx_power = tx_power;
    next_tx_fofs = tx_fofs;
    next_tx_chan = tx_chan;
    next_tx_rng = tx_rng;
    next_tx_skip = 1'b0;
    next_p_rate = p_rate;
    next_p_pwr = p_pwr;
    next_p_fofs = p_fofs;
    next_p_chan = p_chan;
    next_p_rng = p_rng;
    next_f_pwr = f_pwr;
    next_f_big = f_big;
    next_f_fofs = f_fofs;
    next_f_rng = f_rng;
    next_f_chan = f_chan;
    next_f_rate = f_rate;
    // idle cycles since the last burst, this cycle included
    if (state == upstream_pkg::ST_BURST) begin
      next_gap_cnt = 24'h1;
    end else if (gap_cnt != 24'hffffff) begin
      next_gap_cnt = gap_cnt + 24'h1;
    end
    // required gap for whatever is pending plus a modulation change
    mod_chg = (gmod != tx_mod);
    sym_chg = f_rng | f_fofs | f_rate | mod_chg | f_pwr | f_chan;
    need = sym_chg ? gap96 : 24'h0;
    if (f_chan) begin
      need = need + 24'(CHAN_CYC);
    end else if (f_pwr) begin
      need = need + (f_big ? 24'(`PWR_LARGE_CYC) : 24'(`PWR_SMALL_CYC));
    end
    due = $signed(lead - g_time) >= 0;
    ok = gap_cnt >= need;
    pmax = (gmod == upstream_pkg::MOD_QAM16) ? 6'(`PWR_MAX_QAM16)
                                             : 6'(`PWR_MAX_QPSK);
    plim = f_pwr ? p_pwr : tx_power;
    if (plim > pmax) begin
      plim = pmax;
    end
    case (state)
      upstream_pkg::ST_IDLE: begin
        if (g_full && due) begin
          next_g_full = 1'b0;
          if (ok) begin
            // settings change only inside an adequate idle gap
            next_tx_rate = f_rate ? p_rate : tx_rate;
            next_tx_power = plim;
            next_tx_fofs = f_fofs ? p_fofs : tx_fofs;
            next_tx_chan = f_chan ? p_chan : tx_chan;
            next_tx_rng = f_rng ? p_rng : tx_rng;
            next_f_rate = 1'b0;
            next_f_pwr = 1'b0;
            next_f_big = 1'b0;
            next_f_fofs = 1'b0;
            next_f_chan = 1'b0;
            next_f_rng = 1'b0;
          end
          if (ok || !mod_chg) begin
            // without a gap the burst goes out on the settings in force
            next_tx_on = 1'b1;
            next_tx_prof = g_prof;
            next_tx_mod = gmod;
            next_burst_cnt = 24'(g_len) * 24'(slot_cyc);
            next_state = upstream_pkg::ST_BURST;
          end else begin
            next_tx_skip = 1'b1;
          end
        end
      end
      upstream_pkg::ST_BURST: begin
        next_burst_cnt = burst_cnt - 24'h1;
        if (burst_cnt <= 24'h1) begin
          next_tx_on = 1'b0;
          next_state = upstream_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = upstream_pkg::ST_IDLE;
        next_tx_on = 1'b0;
      end
    endcase
    // one grant waits at a time; a zero length is not a grant
    if (link.grant_valid && !g_full && link.grant_len != 8'h0) begin
      next_g_full = 1'b1;
      next_g_time = link.grant_time;
      next_g_len = link.grant_len;
      next_g_prof = link.grant_prof;
    end
    // new commands land after the apply above, so a set wins the clear
    pbase = f_pwr ? p_pwr : tx_power;
    preq = link.pwr_abs ? link.pwr_val - $signed({2'b00, pbase, 2'b00})
                        : link.pwr_val;
    pmag = preq[9] ? 10'(-preq) : 10'(preq);
    pstep = 8'((pmag + 10'h1) >> 2);
    psum = preq[9] ? $signed({3'b000, pbase}) - $signed({1'b0, pstep})
                   : $signed({3'b000, pbase}) + $signed({1'b0, pstep});
    if (link.pwr_valid) begin
      next_f_pwr = 1'b1;
      next_f_big = (f_big & f_pwr) | (pstep > 8'h1);
      if (psum < 9'sd`PWR_MIN) begin
        next_p_pwr = 6'(`PWR_MIN);
      end else if (psum > 9'sd`PWR_MAX_QPSK) begin
        next_p_pwr = 6'(`PWR_MAX_QPSK);
      end else begin
        next_p_pwr = psum[5:0];
      end
    end
    rsum = $signed({2'b00, f_rng ? p_rng : tx_rng}) + 18'(link.rng_adj);
    if (link.rng_valid) begin
      next_f_rng = 1'b1;
      if (rsum < 0) begin
        next_p_rng = 16'h0;
      end else if (rsum > 18'sd`RNG_MAX) begin
        next_p_rng = 16'hffff;
      end else begin
        next_p_rng = rsum[15:0];
      end
    end
    fcl = link.fofs_hz;
    if (fcl > 17'sd`FOFS_MAX) begin
      fcl = 17'sd`FOFS_MAX;
    end else if (fcl < -17'sd`FOFS_MAX) begin
      fcl = -17'sd`FOFS_MAX;
    end
    if (link.fofs_valid) begin
      next_f_fofs = 1'b1;
      next_p_fofs = fcl;
    end
    if (link.chan_valid) begin
      next_f_chan = 1'b1;
      next_p_chan = link.chan_hz;
    end
    if (link.ucd_valid && link.ucd_rate != tx_rate) begin
      next_f_rate = 1'b1;
      next_p_rate = link.ucd_rate;
    end
  end

  // register stage; first burst after reset sees an unlimited gap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= upstream_pkg::ST_IDLE;
      now <= 32'h0;
      g_full <= 1'b0;
      g_time <= 32'h0;
      g_len <= 8'h0;
      g_prof <= 4'h0;
      burst_cnt <= 24'h0;
      gap_cnt <= 24'hffffff;
      tx_on <= 1'b0;
      tx_prof <= 4'h0;
      tx_mod <= upstream_pkg::MOD_QPSK;
      tx_rate <= 3'h0;
      tx_power <= 6'(`PWR_RST);
      tx_fofs <= 17'sh0;
      tx_chan <= 32'h0;
      tx_rng <= 16'h0;
      tx_skip <= 1'b0;
      change_held <= 1'b0;
      p_rate <= 3'h0;
      p_pwr <= 6'(`PWR_RST);
      p_fofs <= 17'sh0;
      p_chan <= 32'h0;
      p_rng <= 16'h0;
      f_pwr <= 1'b0;
      f_big <= 1'b0;
      f_fofs <= 1'b0;
      f_rng <= 1'b0;
      f_chan <= 1'b0;
      f_rate <= 1'b0;
      link.burst_on <= 1'b0;
    end else begin
      state <= next_state;
      now <= next_now;
      g_full <= next_g_full;
      g_time <= next_g_time;
      g_len <= next_g_len;
      g_prof <= next_g_prof;
      burst_cnt <= next_burst_cnt;
      gap_cnt <= next_gap_cnt;
      tx_on <= next_tx_on;
      tx_prof <= next_tx_prof;
      tx_mod <= next_tx_mod;
      tx_rate <= next_tx_rate;
      tx_power <= next_tx_power;
      tx_fofs <= next_tx_fofs;
      tx_chan <= next_tx_chan;
      tx_rng <= next_tx_rng;
      tx_skip <= next_tx_skip;
      change_held <= next_f_pwr | next_f_fofs | next_f_rng | next_f_chan |
                     next_f_rate;
      p_rate <= next_p_rate;
      p_pwr <= next_p_pwr;
      p_fofs <= next_p_fofs;
      p_chan <= next_p_chan;
      p_rng <= next_p_rng;
      f_pwr <= next_f_pwr;
      f_big <= next_f_big;
      f_fofs <= next_f_fofs;
      f_rng <= next_f_rng;
      f_chan <= next_f_chan;
      f_rate <= next_f_rate;
      link.burst_on <= next_tx_on;
    end
  end
endmodule
`default_nettype wire

// ---- logic/head_end_scheduler.sv ----
// head-end end: timestamps, descriptors, corrections and gap-aware grants
`timescale 1ns/1ps
`default_nettype none
`include "upstream_cfg.svh"
module head_end_scheduler #(
  parameter int CHAN_CYC = `CHAN_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  upstream_link_if.head_end link,
  input wire logic cmd_grant_valid,
  input wire logic [31:0] cmd_grant_time,
  input wire logic [7:0] cmd_grant_len,
  input wire logic [3:0] cmd_grant_prof,
  input wire logic cmd_ucd_valid,
  input wire logic [2:0] cmd_ucd_rate,
  input wire logic [15:0] cmd_ucd_slot_cyc,
  input wire logic [3:0] cmd_ucd_prof_idx,
  input wire logic cmd_ucd_prof_mod,
  input wire logic cmd_rng_valid,
  input wire logic signed [15:0] cmd_rng_adj,
  input wire logic cmd_pwr_valid,
  input wire logic cmd_pwr_abs,
  input wire logic signed [9:0] cmd_pwr_val,
  input wire logic cmd_fofs_valid,
  input wire logic signed [16:0] cmd_fofs_hz,
  input wire logic cmd_chan_valid,
  input wire logic [31:0] cmd_chan_hz,
  input wire logic cmd_eq_valid,
  input wire logic [5:0] cmd_eq_idx,
  input wire logic [31:0] cmd_eq_coef,
  output logic [31:0] granted_time,
  output logic grant_moved
);
  logic prof_mod [`NPROF];
  logic [31:0] now, last_end, next_last_end, start, earliest;
  logic [10:0] ts_cnt;
  upstream_pkg::rate_t rate;
  logic [15:0] slot_cyc;
  logic last_mod, next_last_mod, have_last, next_have_last;
  logic chg_sym, chg_pwr, chg_big, chg_chan;
  logic next_chg_sym, next_chg_pwr, next_chg_big, next_chg_chan;
  logic [23:0] neg_guard, next_neg_guard, need, guard_add;
  logic [15:0] neg_mag;
  logic gok, moved;

  always_ff @(posedge clk) begin
    if (cmd_ucd_valid) begin
      prof_mod[cmd_ucd_prof_idx] <= cmd_ucd_prof_mod;
    end
  end

  // guard grows by the cycles of any negative ranging step, rounded up
  assign neg_mag = cmd_rng_adj[15] ? 16'(-cmd_rng_adj) : 16'h0;
  assign guard_add = 24'(({24'h0, neg_mag} * 40'(`RNG_NUM) +
                          40'(`RNG_DEN - 1)) / 40'(`RNG_DEN));

  always_comb begin
    next_last_end = last_end;
    next_last_mod = last_mod;
    next_have_last = have_last;
    next_chg_sym = chg_sym;
    next_chg_pwr = chg_pwr;
    next_chg_big = chg_big;
    next_chg_chan = chg_chan;
    next_neg_guard = neg_guard;
    // gap the modem needs for what changed since the last grant
    need = (chg_sym | chg_pwr | chg_chan |
            (prof_mod[cmd_grant_prof] != last_mod))
           ? 24'(upstream_pkg::sym_cycles(rate)) * 24'(`GAP_SYMS) : 24'h0;
    if (chg_chan) begin
      need = need + 24'(CHAN_CYC);
    end else if (chg_pwr) begin
      need = need + (chg_big ? 24'(`PWR_LARGE_CYC) : 24'(`PWR_SMALL_CYC));
    end
    earliest = last_end + 32'(need) + 32'(neg_guard);
    moved = have_last && ($signed(cmd_grant_time - earliest) < 0);
    start = moved ? earliest : cmd_grant_time;
    gok = cmd_grant_valid && cmd_grant_len != 8'h0;
    if (gok) begin
      next_last_end = start + 32'(24'(cmd_grant_len) * 24'(slot_cyc));
      next_last_mod = prof_mod[cmd_grant_prof];
      next_have_last = 1'b1;
      next_chg_sym = 1'b0;
      next_chg_pwr = 1'b0;
      next_chg_big = 1'b0;
      next_chg_chan = 1'b0;
      next_neg_guard = 24'h0;
    end
    // commands after the grant clear, so a same-cycle change is kept
    if (cmd_rng_valid || cmd_fofs_valid ||
        (cmd_ucd_valid && cmd_ucd_rate != rate)) begin
      next_chg_sym = 1'b1;
    end
    if (cmd_rng_valid) begin
      next_neg_guard = (gok ? 24'h0 : neg_guard) + guard_add;
    end
    if (cmd_pwr_valid) begin
      next_chg_pwr = 1'b1;
      next_chg_big = (chg_big & ~gok) | cmd_pwr_abs |
                     (cmd_pwr_val > 10'sd4) | (cmd_pwr_val < -10'sd4);
    end
    if (cmd_chan_valid) begin
      next_chg_chan = 1'b1;
    end
  end

  // link outputs are registered; timestamps come from the local count, grant time may be pushed later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      now <= 32'h0;
      ts_cnt <= 11'h0;
      rate <= 3'h0;
      slot_cyc <= 16'h0001;
      last_end <= 32'h0;
      last_mod <= 1'b0;
      have_last <= 1'b0;
      chg_sym <= 1'b0;
      chg_pwr <= 1'b0;
      chg_big <= 1'b0;
      chg_chan <= 1'b0;
      neg_guard <= 24'h0;
      granted_time <= 32'h0;
      grant_moved <= 1'b0;
      link.ts_valid <= 1'b0;
      link.ts_time <= 32'h0;
      link.ucd_valid <= 1'b0;
      link.ucd_rate <= 3'h0;
      link.ucd_slot_cyc <= 16'h0001;
      link.ucd_prof_idx <= 4'h0;
      link.ucd_prof_mod <= upstream_pkg::MOD_QPSK;
      link.grant_valid <= 1'b0;
      link.grant_time <= 32'h0;
      link.grant_len <= 8'h0;
      link.grant_prof <= 4'h0;
      link.rng_valid <= 1'b0;
      link.rng_adj <= 16'sh0;
      link.pwr_valid <= 1'b0;
      link.pwr_abs <= 1'b0;
      link.pwr_val <= 10'sh0;
      link.fofs_valid <= 1'b0;
      link.fofs_hz <= 17'sh0;
      link.chan_valid <= 1'b0;
      link.chan_hz <= 32'h0;
      link.eq_valid <= 1'b0;
      link.eq_idx <= 6'h0;
      link.eq_coef <= 32'h0;
    end else begin
      now <= now + 32'h1;
      ts_cnt <= (ts_cnt == 11'(`TS_PERIOD - 1)) ? 11'h0 : ts_cnt + 11'h1;
      link.ts_valid <= (ts_cnt == 11'h0);
      link.ts_time <= now + 32'h1;
      if (cmd_ucd_valid) begin
        rate <= cmd_ucd_rate;
        slot_cyc <= cmd_ucd_slot_cyc;
      end
      last_end <= next_last_end;
      last_mod <= next_last_mod;
      have_last <= next_have_last;
      chg_sym <= next_chg_sym;
      chg_pwr <= next_chg_pwr;
      chg_big <= next_chg_big;
      chg_chan <= next_chg_chan;
      neg_guard <= next_neg_guard;
      if (gok) begin
        granted_time <= start;
        grant_moved <= moved;
      end
      link.ucd_valid <= cmd_ucd_valid;
      link.ucd_rate <= cmd_ucd_rate;
      link.ucd_slot_cyc <= cmd_ucd_slot_cyc;
      link.ucd_prof_idx <= cmd_ucd_prof_idx;
      link.ucd_prof_mod <= upstream_pkg::mod_t'(cmd_ucd_prof_mod);
      link.grant_valid <= gok;
      link.grant_time <= start;
      link.grant_len <= cmd_grant_len;
      link.grant_prof <= cmd_grant_prof;
      link.rng_valid <= cmd_rng_valid;
      link.rng_adj <= cmd_rng_adj;
      link.pwr_valid <= cmd_pwr_valid;
      link.pwr_abs <= cmd_pwr_abs;
      link.pwr_val <= cmd_pwr_val;
      link.fofs_valid <= cmd_fofs_valid;
      link.fofs_hz <= cmd_fofs_hz;
      link.chan_valid <= cmd_chan_valid;
      link.chan_hz <= cmd_chan_hz;
      link.eq_valid <= cmd_eq_valid;
      link.eq_idx <= cmd_eq_idx;
      link.eq_coef <= cmd_eq_coef;
    end
  end
endmodule
`default_nettype wire

// ---- tb/upstream_link_sva.sv ----
// link checker: timestamp cadence, grant sanity and burst framing
`timescale 1ns/1ps
`default_nettype none
module upstream_link_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ts_valid,
  input wire logic [31:0] ts_time,
  input wire logic [15:0] ucd_slot_cyc,
  input wire logic grant_valid,
  input wire logic [31:0] grant_time,
  input wire logic [7:0] grant_len,
  input wire logic burst_on
);
  logic ts_seen, waiting, g_seen;
  logic [10:0] ts_gap;
  logic [31:0] ts_last, g_end, run;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // history of the link; a grant stays owed until some burst starts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ts_seen <= 1'b0;
      waiting <= 1'b0;
      g_seen <= 1'b0;
      ts_gap <= 11'h000;
      ts_last <= 32'h0;
      g_end <= 32'h0;
      run <= 32'h0;
    end else begin
      ts_seen <= ts_seen | ts_valid;
      ts_gap <= ts_valid ? 11'h000 : ts_gap + 11'h001;
      ts_last <= ts_valid ? ts_time : ts_last;
      waiting <= grant_valid | (waiting & ~(burst_on & (run == 32'h0)));
      g_seen <= g_seen | grant_valid;
      g_end <= grant_valid ? grant_time + 32'(grant_len) * 32'(ucd_slot_cyc)
                           : g_end;
      run <= burst_on ? run + 32'h1 : 32'h0;
    end
  end
  a_ts_first: assert property ($rose(rst_b) |=> ts_valid)
    else $error("no timestamp right after reset");
  a_ts_period: assert property (ts_valid && ts_seen |-> ts_gap == 11'd1023)
    else $error("timestamp spacing wrong");
  a_ts_step: assert property (ts_valid && ts_seen |-> ts_time == ts_last + 32'd1024)
    else $error("timestamp value step wrong");
  a_grant_len_ok: assert property (grant_valid |-> grant_len != 8'h00)
    else $error("grant of zero length sent");
  a_reset_quiet: assert property ($rose(rst_b) |-> !burst_on && !grant_valid)
    else $error("link busy at reset release");
  a_launch_granted: assert property (burst_on && run == 32'h0 |-> waiting)
    else $error("burst without grant");
  a_burst_bounded: assert property (burst_on |-> run < 32'd255 * 32'(ucd_slot_cyc))
    else $error("burst longer than any grant");
  a_grant_order: assert property (grant_valid && g_seen |-> grant_time >= g_end)
    else $error("grant overlaps previous grant");
endmodule
`default_nettype wire

// ---- tb/upstream_burst_timing_control_test.sv ----
// testbench: head-end and modem face to face, driven from the user side
`timescale 1ns/1ps
`default_nettype none
module upstream_burst_timing_control_test;
  logic clk = 0, rst_b = 0, gv = 0, uv = 0, um = 0, rv = 0, pv = 0, pa = 0;
  logic fv = 0, cv = 0, ev = 0;
  logic [31:0] gt = 0, ch = 0, ec = 0, ht = 0, quiet = 0;
  logic [7:0] gl = 0;
  logic [3:0] gp = 0, ui = 0;
  logic [2:0] ur = 0;
  logic [15:0] us = 1;
  logic signed [15:0] ra = 0;
  logic signed [9:0] pw = 0;
  logic signed [16:0] fh = 0;
  logic [5:0] ei = 0, rdi = 0;
  logic tx_on, grant_moved;
  logic [3:0] tx_prof;
  upstream_pkg::mod_t tx_mod;
  upstream_pkg::rate_t tx_rate;
  logic [5:0] tx_power;
  logic signed [16:0] tx_fofs;
  logic [31:0] tx_chan, eq_rd_data, granted_time;
  logic [15:0] tx_rng;
  int err_total = 0, checked = 0, adv = 0, q, pe = 55;
  // table rows: kind, value, expected setting, least gap in cycles
  int tk[14] = '{0, 0, 2, 1, 1, 1, 1, 2, 2, 6, 3, 3, 4, 5};
  int tv[14] = '{100, -30, 80, 2, 3, 6, -3, 0, 240, 0, 40000, -123, 'h1234567, 1};
  int te[14] = '{100, 70, 20, 20, 21, 22, 21, 8, 58, 55, 32000, -123, 'h1234567, 1};
  int tn[14] = '{1920, 1920, 2420, 2170, 2170, 2170, 2170, 2420, 2420, 1920,
                 1920, 1920, 2220, 1920};
  upstream_link_if link();
  head_end_scheduler #(.CHAN_CYC(300)) i_head_end_scheduler (
    .clk(clk), .rst_b(rst_b), .link(link), .cmd_grant_valid(gv),
    .cmd_grant_time(gt), .cmd_grant_len(gl), .cmd_grant_prof(gp),
    .cmd_ucd_valid(uv), .cmd_ucd_rate(ur), .cmd_ucd_slot_cyc(us),
    .cmd_ucd_prof_idx(ui), .cmd_ucd_prof_mod(um), .cmd_rng_valid(rv),
    .cmd_rng_adj(ra), .cmd_pwr_valid(pv), .cmd_pwr_abs(pa), .cmd_pwr_val(pw),
    .cmd_fofs_valid(fv), .cmd_fofs_hz(fh), .cmd_chan_valid(cv),
    .cmd_chan_hz(ch), .cmd_eq_valid(ev), .cmd_eq_idx(ei), .cmd_eq_coef(ec),
    .granted_time(granted_time), .grant_moved(grant_moved));
  cable_modem_burst #(.CHAN_CYC(300)) i_cable_modem_burst (
    .clk(clk), .rst_b(rst_b), .link(link), .eq_rd_idx(rdi), .tx_on(tx_on),
    .tx_prof(tx_prof), .tx_mod(tx_mod), .tx_rate(tx_rate),
    .tx_power(tx_power), .tx_fofs(tx_fofs), .tx_chan(tx_chan),
    .tx_rng(tx_rng), .tx_skip(), .change_held(), .eq_rd_data(eq_rd_data));
  upstream_link_sva i_upstream_link_sva (
    .clk(clk), .rst_b(rst_b), .ts_valid(link.ts_valid),
    .ts_time(link.ts_time), .ucd_slot_cyc(link.ucd_slot_cyc),
    .grant_valid(link.grant_valid), .grant_time(link.grant_time),
    .grant_len(link.grant_len), .burst_on(link.burst_on));
  initial forever #10 clk = ~clk;
  // local time as the modem rebuilds it, and idle run before each burst
  always @(posedge clk) begin
    ht <= link.ts_valid ? link.ts_time : ht + 1;
    quiet <= tx_on ? 0 : quiet + 1;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [31:0] got(input int k);
    case (k)
      0: got = 32'(tx_rng);
      3: got = 32'(tx_fofs);
      4: got = tx_chan;
      5: got = 32'(tx_rate);
      default: got = 32'(tx_power);
    endcase
  endfunction
  // one pulse of one kind; kind 6 sends nothing
  task cmd(input int k, input logic [31:0] v);
    @(posedge clk);
    rv <= k == 0;
    pv <= k == 1 || k == 2;
    pa <= k == 2;
    fv <= k == 3;
    cv <= k == 4;
    uv <= k == 5;
    ra <= v[15:0];
    pw <= v[9:0];
    fh <= v[16:0];
    ch <= v;
    ur <= v[2:0];
    @(posedge clk);
    {rv, pv, fv, cv, uv} <= 5'h00;
  endtask
  // grant past advance and gap; the head-end may push it later
  task burst(input logic [3:0] p, input logic [7:0] l, input int need);
    int n;
    @(posedge clk);
    gv <= 1;
    gp <= p;
    gl <= l;
    gt <= ht + 32'(adv + need + 40);
    @(posedge clk);
    gv <= 0;
    n = 0;
    while (tx_on !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1 n++;
    end
    chk("gap", 32'(quiet >= need), 1);
    chk("launch", ht, granted_time - adv + 1);
    chk("profile", {tx_mod, tx_prof}, {p[0], p});
    n = 0;
    while (tx_on === 1'b1 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    chk("length", n, l * 3);
  endtask
  task results;
    $display("mismatches %0d of %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #1600000;
    err_total++;
    results();
  end
  initial begin
    void'($urandom(32'h736f0e7e));
    repeat (16) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    #1 chk("power_reset", tx_power, 8);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      uv <= 1;
      ui <= 4'(i);
      um <= i[0];
      us <= 16'h0003;
    end
    @(posedge clk);
    uv <= 0;
    // coefficient store at both ends of the index range and one at random
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      ev <= 1;
      ei <= i == 0 ? 6'h00 : i == 1 ? 6'h3f : 6'($urandom);
      ec <= $urandom();
      @(posedge clk);
      ev <= 0;
      rdi <= ei;
      repeat (2) @(posedge clk);
      #1 chk("coef", eq_rd_data, ec);
    end
    burst(4'h0, 8'h01, 0);
    for (int i = 0; i < 14; i++) begin
      cmd(tk[i], tv[i]);
      burst(tk[i] == 6 ? 4'h1 : 4'h0, 8'($urandom_range(1, 255)), tn[i]);
      chk("setting", got(tk[i]), te[i]);
      if (tk[i] == 0) adv = te[i] * 312500 / 64000;
    end
    // random fine steps: ties round toward the smaller step
    for (int i = 0; i < 3; i++) begin
      q = $urandom_range(0, 12) - 8;
      cmd(1, 32'(q));
      burst(4'h2, 8'($urandom_range(1, 255)), 3840);
      pe = pe + (q < 0 ? -((1 - q) >> 2) : (q + 1) >> 2);
      chk("power_step", tx_power, pe);
    end
    burst(4'h0, 8'hff, 0);
    results();
  end
endmodule
`default_nettype wire
